// >>> core/spm_map_core.sv
// Sector protection map: serial command decode, erase/program timing, readout
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Notes on behaviour
// - Eight map bytes, byte N holds the protection choice of sector N.
// - Sectors 1 to 7: FFh selects protection, 00h leaves unselected.
// - Sector 0: bits 7:6 first half, bits 5:4 second half, 11 protects.
// - Program only clears bits, so the map must be erased first.
// - After reset every map byte reads 00h.
// - Erase is 3Dh 2Ah 7Fh CFh, started by chip select rising.
// - Busy is shown for the whole erase cycle.
// - Erase works regardless of protection and sets all bytes to FFh.
// - Program is 3Dh 2Ah 7Fh FCh plus eight data bytes, chip select starts it.
// - Busy is shown for the whole program cycle.
// - Bytes not sent before chip select rises are not guaranteed.
// - Data bytes past the eighth wrap to index 0.
// - Program works regardless of protection being enabled.
// - Program uses buffer 1, whose contents are overwritten.
// - Read is 32h and three dummy bytes, then bytes 0 to 7 go out.
// - Output after byte 7 is undefined.
// - Chip select rising ends the read and floats the output.
// - Write-protect low refuses map erase and program.
// ------------------------------------------------------------------

module spm_map_core #(
	parameter int MAP_ERASE_TIME_NS = 2000,
	parameter int MAP_PROGRAM_TIME_NS = 1000
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic wp_n,
	output logic so_out,
	output logic so_oe,
	output logic map_busy,
	output logic [63:0] sector_protect_map,
	output logic [8:0] sector_sel
);
	// Longest times, so whole cycles round down, never below one
	localparam int ERASE_CYC = (MAP_ERASE_TIME_NS / spm_pkg::CLK_PERIOD_NS < 1) ? 1 :
		MAP_ERASE_TIME_NS / spm_pkg::CLK_PERIOD_NS;
	localparam int PROG_CYC = (MAP_PROGRAM_TIME_NS / spm_pkg::CLK_PERIOD_NS < 1) ? 1 :
		MAP_PROGRAM_TIME_NS / spm_pkg::CLK_PERIOD_NS;
	localparam int ERASE_LIM = ERASE_CYC + 2;
	localparam int PROG_LIM = PROG_CYC + 40;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic half_sel(input logic [1:0] f);
		half_sel = (f == spm_pkg::HALF_PROT);
	endfunction : half_sel

	function automatic logic byte_sel(input logic [7:0] b);
		byte_sel = (b == spm_pkg::SEL_ALL);
	endfunction : byte_sel

	// MSB of byte 0 first
	function automatic logic rd_bit(input logic [63:0] m, input logic [6:0] n);
		logic [6:0] k;
		k = n - spm_pkg::READ_LEAD_BITS;
		rd_bit = m[{k[5:3], ~k[2:0]}];
	endfunction : rd_bit

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic sck_s1_reg, sck_s2_reg, sck_d_reg;
	logic cs_s1_reg, cs_s2_reg, cs_d_reg;
	logic si_s1_reg, si_s2_reg;
	logic wp_s1_reg, wp_s2_reg;
	logic sck_rise, sck_fall, cs_act, cs_rise;
	logic [6:0] sh_reg;
	logic [6:0] bit_cnt_reg;
	logic [2:0] bit_pos_reg;
	logic byte_done;
	logic [7:0] byte_val;
	spm_pkg::spm_link_t lk_state_reg;
	logic [2:0] hdr_cnt_reg;
	logic pend_erase_reg, pend_prog_reg, clobber_reg;
	logic [2:0] data_idx_reg;
	spm_pkg::spm_wr_t push_word, pop_word;
	logic push_vld, fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [7:0] buf1_reg [spm_pkg::MAP_BYTES];
	logic [63:0] buf_flat;
	spm_pkg::spm_op_t op_state_reg;
	logic [15:0] tmr_reg;
	logic map_busy_reg;
	logic [63:0] map_reg;
	logic start_ok;
	logic so_out_reg, so_oe_reg;
	logic [8:0] sect_sel_reg;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			{sck_s1_reg, sck_s2_reg, sck_d_reg} <= 3'h0;
			{cs_s1_reg, cs_s2_reg, cs_d_reg} <= 3'h7;
			{si_s1_reg, si_s2_reg} <= 2'h0;
			{wp_s1_reg, wp_s2_reg} <= 2'h3;
		end
		else
		begin
			{sck_s1_reg, sck_s2_reg, sck_d_reg} <= {sck, sck_s1_reg, sck_s2_reg};
			{cs_s1_reg, cs_s2_reg, cs_d_reg} <= {cs_n, cs_s1_reg, cs_s2_reg};
			{si_s1_reg, si_s2_reg} <= {si, si_s1_reg};
			{wp_s1_reg, wp_s2_reg} <= {wp_n, wp_s1_reg};
		end
	end

	assign sck_rise = sck_s2_reg && !sck_d_reg;
	assign sck_fall = !sck_s2_reg && sck_d_reg;
	assign cs_act = !cs_s2_reg;
	assign cs_rise = cs_s2_reg && !cs_d_reg;

	// ----------------------------------------------------------------
	// Bit and byte assembly
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (reset || !cs_act)
		begin
			sh_reg <= 7'h00;
			bit_cnt_reg <= spm_pkg::BIT_CNT_ZERO;
			bit_pos_reg <= spm_pkg::BIT_POS_ZERO;
		end
		else if (sck_rise)
		begin
			sh_reg <= {sh_reg[5:0], si_s2_reg};
			bit_pos_reg <= bit_pos_reg + 3'h1;
			// Saturates so a long read cannot wrap into byte 0 again
			if (bit_cnt_reg != spm_pkg::BIT_CNT_MAX)
			begin
				bit_cnt_reg <= bit_cnt_reg + spm_pkg::BIT_CNT_ONE;
			end
		end
	end

	assign byte_done = cs_act && sck_rise && (bit_pos_reg == spm_pkg::BIT_POS_LAST);
	assign byte_val = {sh_reg, si_s2_reg};

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (reset || !cs_act)
		begin
			lk_state_reg <= spm_pkg::LK_HDR;
			hdr_cnt_reg <= spm_pkg::HDR_BYTE0;
			pend_erase_reg <= 1'b0;
			pend_prog_reg <= 1'b0;
			clobber_reg <= 1'b0;
		end
		else
		begin
			clobber_reg <= 1'b0;
			if (byte_done)
			begin
				case (lk_state_reg)
					spm_pkg::LK_HDR:
					begin
						hdr_cnt_reg <= hdr_cnt_reg + spm_pkg::HDR_STEP;
						// A trailing byte cancels a pending erase
						pend_erase_reg <= 1'b0;
						case (hdr_cnt_reg)
							spm_pkg::HDR_BYTE0:
							begin
								if (byte_val == spm_pkg::CMD_READ_MAP)
									lk_state_reg <= spm_pkg::LK_READ;
								else if (byte_val != spm_pkg::CMD_PREFIX0)
									lk_state_reg <= spm_pkg::LK_SKIP;
							end
							spm_pkg::HDR_BYTE1:
							begin
								if (byte_val != spm_pkg::CMD_PREFIX1)
									lk_state_reg <= spm_pkg::LK_SKIP;
							end
							spm_pkg::HDR_BYTE2:
							begin
								if (byte_val != spm_pkg::CMD_PREFIX2)
									lk_state_reg <= spm_pkg::LK_SKIP;
							end
							spm_pkg::HDR_BYTE3:
							begin
								if (byte_val == spm_pkg::CMD_ERASE_MAP)
									pend_erase_reg <= 1'b1;
								else if (byte_val == spm_pkg::CMD_PROG_MAP)
								begin
									lk_state_reg <= spm_pkg::LK_DATA;
									pend_prog_reg <= 1'b1;
									clobber_reg <= 1'b1;
								end
								else
									lk_state_reg <= spm_pkg::LK_SKIP;
							end
							default: lk_state_reg <= spm_pkg::LK_SKIP;
						endcase
					end
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Program data path through the FIFO into buffer 1
	// ----------------------------------------------------------------
	assign push_vld = byte_done && (lk_state_reg == spm_pkg::LK_DATA);
	assign push_word = '{idx: data_idx_reg, data: byte_val};
	// Drain stalls during an erase; a full FIFO drops the byte uncounted
	assign fifo_out_ready = (op_state_reg != spm_pkg::OP_ERASE);

	always_ff @(posedge clk_sys)
	begin
		if (reset || !cs_act)
			data_idx_reg <= spm_pkg::IDX_ZERO;
		else if (push_vld && fifo_in_ready)
			data_idx_reg <= data_idx_reg + spm_pkg::IDX_STEP;
	end

	spm_fifo #(
		.WIDTH($bits(spm_pkg::spm_wr_t)),
		.DEPTH(spm_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.reset(reset),
		.in_valid(push_vld),
		.in_ready(fifo_in_ready),
		.in_data(push_word),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(pop_word)
	);

	// Unsent bytes stay FFh, so the bitwise program leaves them as they were
	always_ff @(posedge clk_sys)
	begin
		if (reset || clobber_reg)
		begin
			for (int i = 0; i < spm_pkg::MAP_BYTES; i++)
				buf1_reg[i] <= spm_pkg::MAP_ERASED;
		end
		else if (fifo_out_valid && fifo_out_ready)
			buf1_reg[pop_word.idx] <= pop_word.data;
	end

	always_comb
	begin
		for (int i = 0; i < spm_pkg::MAP_BYTES; i++)
			buf_flat[i*8 +: 8] = buf1_reg[i];
	end

	// ----------------------------------------------------------------
	// Self-timed erase and program
	// ----------------------------------------------------------------
	assign start_ok = cs_rise && (bit_pos_reg == spm_pkg::BIT_POS_ZERO) && wp_s2_reg;

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			op_state_reg <= spm_pkg::OP_IDLE;
			tmr_reg <= spm_pkg::TMR_ZERO;
			map_busy_reg <= 1'b0;
			map_reg <= spm_pkg::MAP_RESET;
		end
		else
		begin
			case (op_state_reg)
				spm_pkg::OP_IDLE:
				begin
					if (start_ok && pend_erase_reg)
					begin
						op_state_reg <= spm_pkg::OP_ERASE;
						tmr_reg <= 16'(ERASE_CYC - 1);
						map_busy_reg <= 1'b1;
					end
					else if (start_ok && pend_prog_reg)
					begin
						op_state_reg <= spm_pkg::OP_PROG;
						tmr_reg <= 16'(PROG_CYC - 1);
						map_busy_reg <= 1'b1;
					end
				end
				spm_pkg::OP_ERASE:
				begin
					if (tmr_reg == spm_pkg::TMR_ZERO)
					begin
						map_reg <= {spm_pkg::MAP_BYTES{spm_pkg::MAP_ERASED}};
						op_state_reg <= spm_pkg::OP_IDLE;
						map_busy_reg <= 1'b0;
					end
					else
						tmr_reg <= tmr_reg - spm_pkg::TMR_STEP;
				end
				spm_pkg::OP_PROG:
				begin
					if (tmr_reg != spm_pkg::TMR_ZERO)
						tmr_reg <= tmr_reg - spm_pkg::TMR_STEP;
					else if (!fifo_out_valid)
					begin
						// Cells only go from 1 to 0, hence erase first
						map_reg <= map_reg & buf_flat;
						op_state_reg <= spm_pkg::OP_IDLE;
						map_busy_reg <= 1'b0;
					end
				end
				default: op_state_reg <= spm_pkg::OP_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Map readout
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (reset || !cs_act)
		begin
			so_out_reg <= 1'b0;
			so_oe_reg <= 1'b0;
		end
		else if (sck_fall && (lk_state_reg == spm_pkg::LK_READ) &&
			(bit_cnt_reg >= spm_pkg::READ_LEAD_BITS))
		begin
			so_oe_reg <= 1'b1;
			// Past byte 7 the line just shows zero
			if (bit_cnt_reg < spm_pkg::READ_END_BITS)
				so_out_reg <= rd_bit(map_reg, bit_cnt_reg);
			else
				so_out_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Decoded sector selection
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			sect_sel_reg <= 9'h000;
		else
		begin
			sect_sel_reg[0] <= half_sel(map_reg[spm_pkg::S0A_LSB +: 2]);
			sect_sel_reg[1] <= half_sel(map_reg[spm_pkg::S0B_LSB +: 2]);
			for (int n = 1; n < spm_pkg::MAP_BYTES; n++)
				sect_sel_reg[n+1] <= byte_sel(map_reg[n*8 +: 8]);
		end
	end

	assign so_out = so_out_reg;
	assign so_oe = so_oe_reg;
	assign map_busy = map_busy_reg;
	assign sector_protect_map = map_reg;
	assign sector_sel = sect_sel_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_erase_start;
		op_state_reg == spm_pkg::OP_IDLE && start_ok && pend_erase_reg;
	endsequence

	sequence s_prog_start;
		op_state_reg == spm_pkg::OP_IDLE && start_ok && !pend_erase_reg && pend_prog_reg;
	endsequence

	a_erase_busy_span: assert property (s_erase_start |=> map_busy_reg [*8] ##[1:ERASE_LIM] !map_busy_reg)
		else $error("erase busy span wrong");
	a_erase_fill_ff: assert property ($fell(map_busy_reg) && $past(op_state_reg) == spm_pkg::OP_ERASE |-> map_reg == {spm_pkg::MAP_BYTES{spm_pkg::MAP_ERASED}})
		else $error("erase did not set map to FFh");
	a_prog_busy_span: assert property (s_prog_start |=> map_busy_reg [*8] ##[1:PROG_LIM] !map_busy_reg)
		else $error("program busy span wrong");
	a_prog_clears_only: assert property ($fell(map_busy_reg) && $past(op_state_reg) == spm_pkg::OP_PROG |-> map_reg == ($past(map_reg) & $past(buf_flat)))
		else $error("program result wrong");
	a_wp_refuse: assert property (cs_rise && !wp_s2_reg && !map_busy_reg |=> !map_busy_reg)
		else $error("map changed under write protect");
	a_align_refuse: assert property (cs_rise && bit_pos_reg != spm_pkg::BIT_POS_ZERO && !map_busy_reg |=> !map_busy_reg)
		else $error("unaligned command acted on");
	a_ship_value: assert property ($past(reset) |-> map_reg == spm_pkg::MAP_RESET)
		else $error("map not 00h after reset");
	a_sel_decode: assert property (
		sect_sel_reg[0] == ($past(map_reg[spm_pkg::S0A_LSB +: 2]) == spm_pkg::HALF_PROT)
		&& sect_sel_reg[1] == ($past(map_reg[spm_pkg::S0B_LSB +: 2]) == spm_pkg::HALF_PROT)
		&& sect_sel_reg[2] == ($past(map_reg[15:8]) == spm_pkg::SEL_ALL))
		else $error("sector select decode wrong");
	a_index_wrap: assert property (push_vld && fifo_in_ready && data_idx_reg == 3'h7 |=> data_idx_reg == 3'h0)
		else $error("data index did not wrap");
	a_read_hiz: assert property (cs_rise |=> !so_oe_reg)
		else $error("output driven after chip select rise");
	a_read_first_bit: assert property (sck_fall && cs_act && lk_state_reg == spm_pkg::LK_READ && bit_cnt_reg == spm_pkg::READ_LEAD_BITS |=> so_oe_reg && so_out_reg == $past(map_reg[7]))
		else $error("first read bit wrong");

endmodule : spm_map_core

`default_nettype wire

// >>> inc/spm_pkg.sv
// Constants and types shared by the sector protection map logic
package spm_pkg;

	// ----------------------------------------------------------------
	// Clock and link framing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int FIFO_DEPTH = 16;
	localparam logic [6:0] BIT_CNT_ZERO = 7'h00;
	localparam logic [6:0] BIT_CNT_ONE = 7'h01;
	localparam logic [6:0] BIT_CNT_MAX = 7'h7F;
	localparam logic [2:0] BIT_POS_LAST = 3'h7;
	localparam logic [2:0] BIT_POS_ZERO = 3'h0;
	localparam logic [6:0] READ_LEAD_BITS = 7'h20;
	localparam logic [6:0] READ_END_BITS = 7'h60;

	// ----------------------------------------------------------------
	// Command bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_PREFIX0 = 8'h3D;
	localparam logic [7:0] CMD_PREFIX1 = 8'h2A;
	localparam logic [7:0] CMD_PREFIX2 = 8'h7F;
	localparam logic [7:0] CMD_ERASE_MAP = 8'hCF;
	localparam logic [7:0] CMD_PROG_MAP = 8'hFC;
	localparam logic [7:0] CMD_READ_MAP = 8'h32;
	localparam logic [2:0] HDR_BYTE0 = 3'h0;
	localparam logic [2:0] HDR_BYTE1 = 3'h1;
	localparam logic [2:0] HDR_BYTE2 = 3'h2;
	localparam logic [2:0] HDR_BYTE3 = 3'h3;
	localparam logic [2:0] HDR_STEP = 3'h1;

	// ----------------------------------------------------------------
	// Map layout and values
	// ----------------------------------------------------------------
	localparam int MAP_BYTES = 8;
	localparam logic [63:0] MAP_RESET = 64'h0000000000000000;
	localparam logic [7:0] MAP_ERASED = 8'hFF;
	localparam logic [7:0] SEL_ALL = 8'hFF;
	localparam logic [1:0] HALF_PROT = 2'b11;
	localparam int S0A_LSB = 6;
	localparam int S0B_LSB = 4;
	localparam logic [2:0] IDX_STEP = 3'h1;
	localparam logic [2:0] IDX_ZERO = 3'h0;
	localparam logic [15:0] TMR_ZERO = 16'h0000;
	localparam logic [15:0] TMR_STEP = 16'h0001;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] idx;
		logic [7:0] data;
	} spm_wr_t;

	typedef enum logic [3:0] {
		LK_HDR = 4'h1,
		LK_DATA = 4'h2,
		LK_READ = 4'h4,
		LK_SKIP = 4'h8
	} spm_link_t;

	typedef enum logic [2:0] {
		OP_IDLE = 3'h1,
		OP_ERASE = 3'h2,
		OP_PROG = 3'h4
	} spm_op_t;

endpackage : spm_pkg

// >>> core/spm_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module spm_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] rd_ptr_reg;
	logic full;
	logic empty;

	// Extra pointer bit tells full from empty
	assign empty = (wr_ptr_reg == rd_ptr_reg);
	assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem_reg[rd_ptr_reg[AW-1:0]];

	always_ff @(posedge clk_sys)
	begin
		if (in_valid && !full)
		begin
			mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end
		else
		begin
			if (in_valid && !full)
			begin
				wr_ptr_reg <= wr_ptr_reg + (AW+1)'(1);
			end
			if (out_ready && !empty)
			begin
				rd_ptr_reg <= rd_ptr_reg + (AW+1)'(1);
			end
		end
	end

endmodule : spm_fifo

`default_nettype wire

// >>> dv/spm_host_model.sv
// Host-side link controller model that drives framed serial commands
`timescale 1ns/1ps
`default_nettype none

module spm_host_model (
	input wire logic clk_sys,
	output logic sck,
	output logic cs_n,
	output logic si,
	input wire logic so_line
);
	// ----------------------------------------------------------------
	// Frame driver
	// ----------------------------------------------------------------
	initial
	begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end

	// Clock stands low between frames, half period 100 ns, own phase
	task automatic frame(input logic [7:0] tx[$], input int nbits, output logic [7:0] rx[$]);
		logic [7:0] sh;
		rx = {};
		repeat (16) @(posedge clk_sys);
		#1 cs_n = 1'b0;
		#37;
		for (int i = 0; i < nbits; i++)
		begin
			si = tx[i / 8][7 - i % 8];
			#100 sck = 1'b1;
			#100;
			// Late sample leaves margin for the synchronised output
			sh = {sh[6:0], so_line};
			if (i % 8 == 7)
				rx.push_back(sh);
			sck = 1'b0;
		end
		#100 cs_n = 1'b1;
		// Released data line shows the inverse, not a stale bit
		si = ~si;
	endtask : frame
endmodule : spm_host_model

`default_nettype wire

// >>> dv/sector_protect_map_access_test.sv
// Self-checking bench for the sector protection map core
`timescale 1ns/1ps
`default_nettype none

module sector_protect_map_access_test;
	// ----------------------------------------------------------------
	// Signals and design
	// ----------------------------------------------------------------
	localparam int ERASE_NS = 2000;
	localparam int PROG_NS = 1000;
	localparam int ERASE_CYC = ERASE_NS / spm_pkg::CLK_PERIOD_NS;
	localparam int PROG_CYC = PROG_NS / spm_pkg::CLK_PERIOD_NS;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic wp_n = 1'b1;
	logic sck;
	logic cs_n;
	logic si;
	logic so_out;
	logic so_oe;
	logic map_busy;
	logic [63:0] sector_protect_map;
	logic [8:0] sector_sel;
	wire logic so_line;
	int fail_count = 0;
	int cmp_count = 0;
	int seed = 68;
	int cycles = 0;
	logic [7:0] map_m [8];
	logic [7:0] tx [$];
	logic [7:0] rx [$];

	assign so_line = so_oe ? so_out : 1'bz;

	always #12.5 clk_sys = ~clk_sys;

	spm_map_core #(.MAP_ERASE_TIME_NS(ERASE_NS), .MAP_PROGRAM_TIME_NS(PROG_NS)) u_spm_map_core (
		.clk_sys(clk_sys),
		.reset(reset),
		.sck(sck),
		.cs_n(cs_n),
		.si(si),
		.wp_n(wp_n),
		.so_out(so_out),
		.so_oe(so_oe),
		.map_busy(map_busy),
		.sector_protect_map(sector_protect_map),
		.sector_sel(sector_sel)
	);

	spm_host_model u_spm_host_model (
		.clk_sys(clk_sys),
		.sck(sck),
		.cs_n(cs_n),
		.si(si),
		.so_line(so_line)
	);

	// ----------------------------------------------------------------
	// Checks and reference model
	// ----------------------------------------------------------------
	task automatic complete_run();
		if (fail_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run

	task automatic check_val(input string name, input logic [63:0] exp, input logic [63:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : check_val

	task automatic tick();
		@(posedge clk_sys);
		#2;
	endtask : tick

	function automatic logic [7:0] legal(input int n);
		int r;
		r = $random(seed);
		if (n == 0)
			return {r[1] ? 2'b11 : 2'b00, r[2] ? 2'b11 : 2'b00, r[7:4]};
		return r[0] ? 8'hFF : 8'h00;
	endfunction : legal

	task automatic check_state();
		logic [63:0] m;
		logic [8:0] s;
		for (int i = 0; i < 8; i++)
			m[8 * i +: 8] = map_m[i];
		s[0] = map_m[0][7:6] == 2'b11;
		s[1] = map_m[0][5:4] == 2'b11;
		for (int n = 1; n < 8; n++)
			s[n + 1] = map_m[n] == 8'hFF;
		check_val("map", m, sector_protect_map);
		check_val("sector_sel", 64'(s), 64'(sector_sel));
	endtask : check_state

	// Sends the frame, then times the busy cycle it should start
	task automatic run_cmd(input int nbits, input int cyc, input logic ok);
		int n;
		u_spm_host_model.frame(tx, nbits, rx);
		n = 0;
		for (int w = 0; w < 12 && map_busy !== 1'b1; w++)
			tick();
		while (map_busy === 1'b1 && n < 300)
		begin
			tick();
			n++;
		end
		check_val("busy_cycles", 64'(ok), 64'(n >= cyc && n <= cyc + 3));
		tick();
		check_state();
	endtask : run_cmd

	task automatic erase_map();
		tx = {8'h3D, 8'h2A, 8'h7F, 8'hCF};
		for (int i = 0; i < 8; i++)
			map_m[i] = 8'hFF;
		run_cmd(32, ERASE_CYC, 1'b1);
	endtask : erase_map

	task automatic program_map(input int nbytes);
		logic [7:0] buf_m [8];
		logic [7:0] d;
		tx = {8'h3D, 8'h2A, 8'h7F, 8'hFC};
		for (int i = 0; i < 8; i++)
			buf_m[i] = 8'hFF;
		for (int k = 0; k < nbytes; k++)
		begin
			d = legal(k % 8);
			tx.push_back(d);
			buf_m[k % 8] = d;
		end
		for (int i = 0; i < 8; i++)
			if (wp_n)
				map_m[i] = map_m[i] & buf_m[i];
		run_cmd(32 + 8 * nbytes, PROG_CYC, wp_n);
	endtask : program_map

	task automatic read_map();
		tx = {8'h32};
		for (int k = 0; k < 11; k++)
			tx.push_back(8'($random(seed)));
		u_spm_host_model.frame(tx, 96, rx);
		for (int k = 0; k < 8; k++)
			check_val("read_byte", 64'(map_m[k]), 64'(rx[k + 4]));
		repeat (8) tick();
		check_val("so_oe_idle", 64'(1'b0), 64'(so_oe));
	endtask : read_map

	// ----------------------------------------------------------------
	// Sequence and hang guard
	// ----------------------------------------------------------------
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			fail_count++;
			complete_run();
		end
	end

	initial
	begin
		for (int i = 0; i < 8; i++)
			map_m[i] = 8'h00;
		repeat (10) @(posedge clk_sys);
		#1 reset = 1'b0;
		tick();
		tick();
		check_state();
		check_val("busy_idle", 64'(1'b0), 64'(map_busy));
		read_map();
		// Refused requests leave the map untouched
		@(posedge clk_sys) #1 wp_n = 1'b0;
		tx = {8'h3D, 8'h2A, 8'h7F, 8'hCF};
		run_cmd(32, ERASE_CYC, 1'b0);
		@(posedge clk_sys) #1 wp_n = 1'b1;
		run_cmd(31, ERASE_CYC, 1'b0);
		tx.push_back(8'h00);
		run_cmd(33, ERASE_CYC, 1'b0);
		run_cmd(40, ERASE_CYC, 1'b0);
		// Only a handful of map rewrites, far below the endurance limit
		erase_map();
		program_map(8);
		read_map();
		program_map(8);
		erase_map();
		program_map(9);
		program_map(3);
		read_map();
		@(posedge clk_sys) #1 wp_n = 1'b0;
		program_map(8);
		@(posedge clk_sys) #1 wp_n = 1'b1;
		erase_map();
		read_map();
		complete_run();
	end
endmodule : sector_protect_map_access_test

`default_nettype wire
